// [core/cct_pkg.sv]
// constants for the capture/compare timer unit
package cct_pkg;
  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_COUNT = 8'h00;
  localparam logic [7:0] OFS_CMP_A = 8'h04;
  localparam logic [7:0] OFS_CMP_B = 8'h08;
  localparam logic [7:0] OFS_CAPT = 8'h0C;
  localparam logic [7:0] OFS_PRESC = 8'h10;
  localparam logic [7:0] OFS_RUN = 8'h14;
  localparam logic [7:0] OFS_CFG = 8'h18;
  localparam logic [7:0] OFS_EDGE = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [7:0] OFS_MASK = 8'h24;
  localparam logic [7:0] OFS_OUTC = 8'h28;
  // reset values
  localparam logic [3:0] PRESC_RST = 4'h1;
  localparam logic [7:0] CFG_RST = 8'h10;
  localparam logic [7:0] RUN_RST = 8'h00;
  localparam logic [3:0] EDGE_RST = 4'h0;
  // run register fields
  localparam int RUN_EN = 0;
  localparam int RUN_WIDE = 1;
  // config register fields
  localparam int CFG_CAPMODE = 2;
  localparam int CFG_CLR_B = 3;
  localparam int CFG_CLR_CAP = 5;
  // edge register fields: [1:0] input a, [3:2] input b (01 rise, 10 fall, 11 both)
  localparam int EDGE_A_LO = 0;
  localparam int EDGE_B_LO = 2;
  // status bits
  localparam int ST_MATCH_A = 0;
  localparam int ST_MATCH_B = 1;
  localparam int ST_EXT_A = 2;
  localparam int ST_EXT_B = 3;
  localparam int ST_WRAP = 4;
  localparam int ST_W = 5;
  // prescaler: select code k (0..8) divides the oscillator by 8<<k; code 4'hF is external
  localparam logic [3:0] PRESC_MAX = 4'h8;
  localparam logic [3:0] PRESC_EXT = 4'hF;
  localparam int DIV_BASE = 8;
  localparam int DIV_W = 11;
endpackage : cct_pkg

// [core/cct_timer.sv]
// capture/compare timer unit with AHB-Lite register slave
// What this block does
// - interval interrupt each compare period, step is one count clock (osc/8..osc/2048)
// - counter runs as 8-bit or 16-bit
// - counter increments each count clock chosen by the 4-bit prescaler select code
// - run-enable bit starts or halts counting; halted count holds except when a capture edge with clear enabled resets it
// - reset clears the count and stops counting
// - count equals primary compare: raise primary irq and toggle output a
// - compare registers follow the selected counter width
// - compare and capture/compare registers are not reset
// - secondary register is compare or capture per config register
// - two outputs toggle independently, half period one to 65536 counts
// - pulse widths on both external inputs captured in count clock units
// - event mode counts chosen edges on external input b
// - secondary match raises secondary irq, toggles output b, may clear count
// - capture loads count on input b edge, may clear count
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cct_timer (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_irq_input_a,
  input wire logic ext_irq_input_b,
  output logic timer_out_a,
  output logic timer_out_b,
  output logic primary_match_irq,
  output logic secondary_match_irq,
  output logic irq
);
  localparam int ST_W_L = cct_pkg::ST_W;
  // bus address phase capture
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  // timer state
  logic [15:0] count_reg, count_next;
  logic [15:0] cmp_a_reg, cmp_a_next;
  logic [15:0] cmp_b_reg, cmp_b_next;
  logic [15:0] capt_reg, capt_next;
  logic [3:0] presc_reg, presc_next;
  logic [7:0] run_reg, run_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [3:0] edge_reg, edge_next;
  logic [ST_W_L-1:0] stat_reg, stat_next;
  logic [ST_W_L-1:0] mask_reg, mask_next;
  logic [3:0] outc_reg, outc_next;
  logic [cct_pkg::DIV_W-1:0] div_reg, div_next;
  logic in_a_reg, in_a_next, in_b_reg, in_b_next;
  logic out_a_reg, out_a_next, out_b_reg, out_b_next;
  logic pm_reg, pm_next, sm_reg, sm_next;

  logic addr_ph, tick, wide, edge_a, edge_b, match_a, match_b, wrap, clr;
  logic [15:0] inc, wmask;
  logic [cct_pkg::DIV_W-1:0] div_top;

  assign addr_ph = hsel && hready && htrans[1];
  assign wide = run_reg[cct_pkg::RUN_WIDE];
  assign wmask = wide ? 16'hFFFF : 16'h00FF;
  // prescaler division: 8 << code, minus one as terminal count
  assign div_top = cct_pkg::DIV_W'((cct_pkg::DIV_BASE << presc_reg) - 1);

  // edge detectors, inputs taken as synchronous
  function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
    edge_hit = (sel[0] && !prev && cur) || (sel[1] && prev && !cur);
  endfunction : edge_hit
  assign edge_a = edge_hit(in_a_reg, ext_irq_input_a,
                           edge_reg[cct_pkg::EDGE_A_LO +: 2]);
  assign edge_b = edge_hit(in_b_reg, ext_irq_input_b,
                           edge_reg[cct_pkg::EDGE_B_LO +: 2]);

  always_comb begin
    // external clock counts input b edges; internal from divider
    if (presc_reg == cct_pkg::PRESC_EXT) begin
      tick = run_reg[cct_pkg::RUN_EN] && edge_b;
    end else begin
      tick = run_reg[cct_pkg::RUN_EN] && (presc_reg <= cct_pkg::PRESC_MAX)
             && (div_reg == div_top);
    end
  end

  assign inc = (count_reg + 16'h0001) & wmask;
  assign wrap = tick && (inc == 16'h0000);
  // match seen only when the count steps onto the value
  assign match_a = tick && (inc == (cmp_a_reg & wmask));
  assign match_b = tick && !cfg_reg[cct_pkg::CFG_CAPMODE]
                   && (inc == (cmp_b_reg & wmask));
  assign clr = (match_b && cfg_reg[cct_pkg::CFG_CLR_B])
               || (edge_b && cfg_reg[cct_pkg::CFG_CAPMODE] && cfg_reg[cct_pkg::CFG_CLR_B])
               || (edge_a && cfg_reg[cct_pkg::CFG_CLR_CAP]);

  // bus side: write address held for the data phase, read data from flops
  always_comb begin
    wr_pend_next = addr_ph && hwrite;
    wr_addr_next = addr_ph ? haddr : wr_addr_reg;
    rdata_next = 32'h0000_0000;
    // read data registered at the end of the address phase, so zero wait states
    if (addr_ph && !hwrite) begin
      unique case (haddr)
        cct_pkg::OFS_COUNT: rdata_next = {16'h0000, count_reg & wmask};
        cct_pkg::OFS_CMP_A: rdata_next = {16'h0000, cmp_a_reg & wmask};
        cct_pkg::OFS_CMP_B: rdata_next = {16'h0000, cmp_b_reg & wmask};
        cct_pkg::OFS_CAPT: rdata_next = {16'h0000, capt_reg & wmask};
        cct_pkg::OFS_PRESC: rdata_next = {28'h0000000, presc_reg};
        cct_pkg::OFS_RUN: rdata_next = {24'h000000, run_reg};
        cct_pkg::OFS_CFG: rdata_next = {24'h000000, cfg_reg};
        cct_pkg::OFS_EDGE: rdata_next = {28'h0000000, edge_reg};
        cct_pkg::OFS_STAT: rdata_next = {27'h0000000, stat_reg};
        cct_pkg::OFS_MASK: rdata_next = {27'h0000000, mask_reg};
        cct_pkg::OFS_OUTC: rdata_next = {28'h0000000, outc_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // counter, prescaler, capture and control registers
  always_comb begin
    count_next = count_reg;
    cmp_a_next = cmp_a_reg;
    cmp_b_next = cmp_b_reg;
    capt_next = capt_reg;
    presc_next = presc_reg;
    run_next = run_reg;
    cfg_next = cfg_reg;
    edge_next = edge_reg;
    mask_next = mask_reg;
    outc_next = outc_reg;
    div_next = div_reg;
    // prescaler restarts when halted so the first step is a full count clock
    if (!run_reg[cct_pkg::RUN_EN] || div_reg >= div_top) begin
      div_next = '0;
    end else begin
      div_next = div_reg + 1'b1;
    end
    // clear wins over the step: the counter never shows the matching value
    if (clr) begin
      count_next = 16'h0000;
    end else if (tick) begin
      count_next = inc;
    end
    if (edge_a) begin
      capt_next = count_reg & wmask;
    end
    // software writes, data phase
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        cct_pkg::OFS_CMP_A: cmp_a_next = hwdata[15:0] & wmask;
        cct_pkg::OFS_CMP_B: cmp_b_next = hwdata[15:0] & wmask;
        cct_pkg::OFS_PRESC: presc_next = hwdata[3:0];
        cct_pkg::OFS_RUN: run_next = hwdata[7:0];
        cct_pkg::OFS_CFG: cfg_next = hwdata[7:0];
        cct_pkg::OFS_EDGE: edge_next = hwdata[3:0];
        cct_pkg::OFS_MASK: mask_next = hwdata[ST_W_L-1:0];
        cct_pkg::OFS_OUTC: outc_next = hwdata[3:0];
        default: ; // count has no write path, status has its own process
      endcase
    end
    // capture after the write so a trigger wins
    if (edge_b && cfg_reg[cct_pkg::CFG_CAPMODE]) begin
      cmp_b_next = count_reg & wmask;
    end
  end

  // sticky status, write one to clear; set beats clear so no event is lost
  always_comb begin
    stat_next = stat_reg;
    if (wr_pend_reg && wr_addr_reg == cct_pkg::OFS_STAT) begin
      stat_next = stat_reg & ~hwdata[ST_W_L-1:0];
    end
    stat_next[cct_pkg::ST_MATCH_A] = stat_next[cct_pkg::ST_MATCH_A] | match_a;
    stat_next[cct_pkg::ST_MATCH_B] = stat_next[cct_pkg::ST_MATCH_B] | match_b;
    stat_next[cct_pkg::ST_EXT_A] = stat_next[cct_pkg::ST_EXT_A] | edge_a;
    stat_next[cct_pkg::ST_EXT_B] = stat_next[cct_pkg::ST_EXT_B] | edge_b;
    // a cleared wrap is not reported, the clear already restarted the count
    stat_next[cct_pkg::ST_WRAP] = stat_next[cct_pkg::ST_WRAP] | (wrap && !clr);
  end

  // pin side: edge history and toggle outputs
  always_comb begin
    // history resets low, the idle level, so no false edge follows reset
    in_a_next = ext_irq_input_a;
    in_b_next = ext_irq_input_b;
    out_a_next = out_a_reg;
    out_b_next = out_b_reg;
    if (match_a && outc_reg[0]) begin
      out_a_next = !out_a_reg;
    end
    if (match_b && outc_reg[1]) begin
      out_b_next = !out_b_reg;
    end
    pm_next = match_a;
    sm_next = match_b;
  end

  // bus group
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // counter group
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 16'h0000;
      capt_reg <= 16'h0000;
      div_reg <= '0;
    end else begin
      count_reg <= count_next;
      capt_reg <= capt_next;
      div_reg <= div_next;
    end
  end

  // control group
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_reg <= cct_pkg::RUN_RST;
      presc_reg <= cct_pkg::PRESC_RST;
      cfg_reg <= cct_pkg::CFG_RST;
      edge_reg <= cct_pkg::EDGE_RST;
      mask_reg <= '0;
      outc_reg <= 4'h0;
    end else begin
      run_reg <= run_next;
      presc_reg <= presc_next;
      cfg_reg <= cfg_next;
      edge_reg <= edge_next;
      mask_reg <= mask_next;
      outc_reg <= outc_next;
    end
  end

  // status group
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // edge history group
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_a_reg <= 1'b0;
      in_b_reg <= 1'b0;
    end else begin
      in_a_reg <= in_a_next;
      in_b_reg <= in_b_next;
    end
  end

  // output group
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
      pm_reg <= 1'b0;
      sm_reg <= 1'b0;
    end else begin
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      pm_reg <= pm_next;
      sm_reg <= sm_next;
    end
  end

  // compare values have no reset on purpose
  always_ff @(posedge core_clk) begin
    cmp_a_reg <= cmp_a_next;
    cmp_b_reg <= cmp_b_next;
  end

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign timer_out_a = out_a_reg;
  assign timer_out_b = out_b_reg;
  assign primary_match_irq = pm_reg;
  assign secondary_match_irq = sm_reg;
  assign irq = |(stat_reg & mask_reg);
endmodule : cct_timer
`default_nettype wire

// [bench/cct_timer_monitor.sv]
// port assertions for the timer unit
`timescale 1ns/100ps
`default_nettype none
module cct_timer_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic timer_out_a,
  input wire logic timer_out_b,
  input wire logic primary_match_irq,
  input wire logic secondary_match_irq,
  input wire logic irq
);
  logic rd_q;
  // read data phase marker, data only stands here
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) rd_q <= 1'b0;
    else rd_q <= hsel && hready && htrans[1] && !hwrite;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_bus_ok: assert property (hreadyout && !hresp) else $error("slave stalled or error");
  chk_pulse_a: assert property (primary_match_irq |=> !primary_match_irq)
    else $error("primary pulse too long");
  chk_pulse_b: assert property (secondary_match_irq |=> !secondary_match_irq)
    else $error("secondary pulse too long");
  chk_toggle_a: assert property ($changed(timer_out_a) |->
    $past(primary_match_irq) or ##[0:1] primary_match_irq) else $error("out a stray");
  chk_toggle_b: assert property ($changed(timer_out_b) |->
    $past(secondary_match_irq) or ##[0:1] secondary_match_irq) else $error("out b stray");
  chk_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0) else $error("read data idle");
  chk_rdata_upper: assert property (rd_q |-> hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
  chk_reset_quiet: assert property (!$past(arst_n) |-> !irq && !timer_out_a && !timer_out_b)
    else $error("outputs active after reset");
  cover property (secondary_match_irq);
  cover property (primary_match_irq);
  cover property (irq);
endmodule : cct_timer_monitor
bind cct_timer cct_timer_monitor cct_timer_monitor_inst (.core_clk(core_clk), .arst_n(arst_n),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .timer_out_a(timer_out_a), .timer_out_b(timer_out_b),
  .primary_match_irq(primary_match_irq), .secondary_match_irq(secondary_match_irq), .irq(irq));
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the timer unit
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ea = 1'b0;
  logic eb = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd_smp, r, c;
  logic hreadyout, hresp, toa, tob, pia, pib, irq, o;
  int mismatches = 0;
  int compares = 0;
  int n;
  cct_timer cct_timer_inst (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_input_a(ea),
    .ext_irq_input_b(eb), .timer_out_a(toa), .timer_out_b(tob), .primary_match_irq(pia),
    .secondary_match_irq(pib), .irq(irq));
  initial forever #5 core_clk = ~core_clk;
  // pre-edge copy so read data is taken at the answer edge without a race
  always @(posedge core_clk) rd_smp <= hrdata;
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic hold;
    int k;
    k = 0;
    do begin @(posedge core_clk); k++; end while (hreadyout !== 1'b1 && k < 20);
    if (k >= 20) begin mismatches++; end_of_test(); end
  endtask : hold
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1; hwrite <= w; haddr <= a; htrans <= 2'h2;
    hold();
    htrans <= 2'h0; hwdata <= d;
    hold();
    #1 r = rd_smp;
  endtask : bus
  task automatic wait_b;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pib !== 1'b1 && n < 600);
    if (n >= 600) begin mismatches++; end_of_test(); end
  endtask : wait_b
  task automatic t_reset;
    bus(1'b0, cct_pkg::OFS_PRESC, 32'h0);
    check("prescaler", r, 32'h1);
    bus(1'b0, cct_pkg::OFS_CFG, 32'h0);
    check("config", r, 32'h10);
    bus(1'b0, cct_pkg::OFS_RUN, 32'h0);
    check("run", r, 32'h0);
    bus(1'b1, cct_pkg::OFS_COUNT, 32'h5);
    bus(1'b0, cct_pkg::OFS_COUNT, 32'h0);
    check("count", r, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", r, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_interval;
    bus(1'b1, cct_pkg::OFS_CMP_B, 32'h3);
    bus(1'b1, cct_pkg::OFS_CMP_A, 32'h2);
    bus(1'b1, cct_pkg::OFS_CFG, 32'h18);
    bus(1'b1, cct_pkg::OFS_PRESC, 32'h0);
    bus(1'b1, cct_pkg::OFS_OUTC, 32'h3);
    bus(1'b1, cct_pkg::OFS_MASK, 32'h2);
    bus(1'b1, cct_pkg::OFS_RUN, 32'h1);
    wait_b();
    wait_b();
    check("period", n, 32'h18);
    repeat (2) @(posedge core_clk);
    o = tob;
    wait_b();
    repeat (2) @(posedge core_clk);
    check("out b", tob, !o);
    check("irq on", irq, 1'b1);
    bus(1'b0, cct_pkg::OFS_STAT, 32'h0);
    check("status", r & 32'h3, 32'h3);
    bus(1'b1, cct_pkg::OFS_MASK, 32'h0);
    check("irq masked", irq, 1'b0);
    bus(1'b1, cct_pkg::OFS_RUN, 32'h0);
    bus(1'b1, cct_pkg::OFS_STAT, 32'h1F);
    bus(1'b0, cct_pkg::OFS_STAT, 32'h0);
    check("status clear", r, 32'h0);
    bus(1'b0, cct_pkg::OFS_COUNT, 32'h0);
    c = r;
    repeat (40) @(posedge core_clk);
    bus(1'b0, cct_pkg::OFS_COUNT, 32'h0);
    check("halted", r, c);
    $display("test interval done");
  endtask : t_interval
  task automatic t_width;
    bus(1'b1, cct_pkg::OFS_CMP_B, 32'h1FF);
    bus(1'b0, cct_pkg::OFS_CMP_B, 32'h0);
    check("narrow cmp", r, 32'hFF);
    bus(1'b1, cct_pkg::OFS_RUN, 32'h2);
    bus(1'b1, cct_pkg::OFS_CMP_B, 32'h1FF);
    bus(1'b0, cct_pkg::OFS_CMP_B, 32'h0);
    check("wide cmp", r, 32'h1FF);
    $display("test width done");
  endtask : t_width
  task automatic t_capture;
    bus(1'b1, cct_pkg::OFS_CFG, 32'h14);
    bus(1'b1, cct_pkg::OFS_EDGE, 32'h5);
    bus(1'b1, cct_pkg::OFS_RUN, 32'h3);
    repeat (40) @(posedge core_clk);
    ea <= 1'b1;
    eb <= 1'b1;
    repeat (8) @(posedge core_clk);
    bus(1'b1, cct_pkg::OFS_RUN, 32'h2);
    ea <= 1'b0;
    eb <= 1'b0;
    bus(1'b0, cct_pkg::OFS_CAPT, 32'h0);
    c = r;
    bus(1'b0, cct_pkg::OFS_CMP_B, 32'h0);
    check("capture pair", r, c);
    check("capture loaded", r != 32'h0, 1'b1);
    bus(1'b0, cct_pkg::OFS_STAT, 32'h0);
    check("edge status", r & 32'hC, 32'hC);
    $display("test capture done");
  endtask : t_capture
  task automatic t_event;
    bus(1'b1, cct_pkg::OFS_CFG, 32'h10);
    bus(1'b1, cct_pkg::OFS_EDGE, 32'hC);
    bus(1'b1, cct_pkg::OFS_PRESC, 32'hF);
    // system clock equals the oscillator here, so count reads are allowed
    bus(1'b0, cct_pkg::OFS_COUNT, 32'h0);
    c = r;
    bus(1'b1, cct_pkg::OFS_RUN, 32'h3);
    for (int i = 0; i < 10; i++) begin
      repeat (4) @(posedge core_clk);
      eb <= ~eb;
    end
    repeat (8) @(posedge core_clk);
    bus(1'b0, cct_pkg::OFS_COUNT, 32'h0);
    check("events", r, c + 32'hA);
    $display("test event done");
  endtask : t_event
  initial begin
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_interval();
    t_width();
    t_capture();
    t_event();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
